/* pkg/pwrseq_pkg.sv */
package pwrseq_pkg;

    // Timebase
    localparam int CLK_HZ         = 50_000_000;
    localparam int MS_CYCLES      = CLK_HZ / 1000;
    localparam int TICK_W         = 16;
    localparam int MS_W           = 5;

    // Settling times in milliseconds
    localparam int AUX_SETTLE_MS  = 15;
    localparam int RAIL_SETTLE_MS = 5;
    localparam int LOCK_SETTLE_MS = 5;
    localparam int RST_STEP_MS    = 5;
    localparam int BOOT_HOLD_MS   = 1;
    localparam int PD_CLK_MS      = 5;

    // Sequenced rail count and enable bit positions
    localparam int NRAIL          = 8;
    localparam int R_CORE_ADAPT   = 0;
    localparam int R_CORE_FIXED   = 1;
    localparam int R_0V85         = 2;
    localparam int R_MAIN_1V8     = 3;
    localparam int R_MEM_1V5      = 4;
    localparam int R_MEM_TERM     = 5;
    localparam int R_MAIN_3V3     = 6;
    localparam int R_5V           = 7;
    localparam logic [2:0] RAIL_LAST = 3'h7;
    localparam int BOOT_W         = 8;

    typedef enum logic [3:0] {
        ST_OFF      = 4'h0,
        ST_AUX      = 4'h1,
        ST_RAILS    = 4'h3,
        ST_CLKGEN   = 4'h2,
        ST_LOCK     = 4'h6,
        ST_POR      = 4'h7,
        ST_FULL     = 4'h5,
        ST_BOOT     = 4'h4,
        ST_RUN      = 4'hC,
        ST_PD_RST   = 4'hD,
        ST_PD_OFF   = 4'hF
    } seq_state_t;

    // Outputs toward the SoC
    typedef struct packed {
        logic                warm_reset_n;
        logic                power_on_reset_n;
        logic                full_reset_n;
        logic                nmi_release;
        logic                boot_oe;
        logic [BOOT_W-1:0]   boot_out;
    } soc_ctl_t;

endpackage

/* rtl/board_power_reset_sequencer.sv */
`timescale 1ns/1ps
// Contract
// - With payload power, enable aux 3.3V and logic rails together; SoC outputs held low.
// - Enable adaptive core rail after aux rail stable 15 ms.
// - Enable fixed core rail 5 ms after adaptive core stable.
// - Enable 0.85V rail after fixed core stable 5 ms.
// - Enable 1.8V main rail after 0.85V stable 5 ms.
// - Enable 1.5V memory rail after 1.8V main stable 5 ms.
// - Enable 0.75V termination rail after 1.5V stable 5 ms.
// - Enable main 3.3V rail after termination rail stable 5 ms.
// - Enable 5V rail after main 3.3V stable 5 ms.
// - After 5V stable 5 ms release clock-gen power-down, start init.
// - Release warm reset, unlock outputs, NMI after SoC good and lock 5 ms.
// - Drive boot-configuration pins during reset release.
// - Release power-on reset 5 ms after warm reset release.
// - Release full reset 5 ms after power-on reset release.
// - Stop driving boot pins 1 ms after full reset release.
// - On power failure assert full and power-on resets immediately.
// - 5 ms into power-down, lock outputs, clock-gen power-down low.
// - Finally switch off all rails together, aux and logic included.
module board_power_reset_sequencer #(
    parameter int                     NRAIL  = pwrseq_pkg::NRAIL,
    parameter int                     BOOT_W = pwrseq_pkg::BOOT_W,
    parameter logic [15:0]            MS_CYCLES = 16'(pwrseq_pkg::MS_CYCLES)
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 payload_present,
    input  wire logic                 power_fail,
    input  wire logic                 aux_power_good,
    input  wire logic [NRAIL-1:0]     rail_power_good,
    input  wire logic                 soc_power_good,
    input  wire logic                 clockgen_locked,
    input  wire logic [BOOT_W-1:0]    boot_config,
    output logic                      auxiliary_rail_3v3,
    output logic                      logic_core_rail_1v2,
    output logic                      logic_io_rail_1v8,
    output logic [NRAIL-1:0]          rail_enable,
    output logic                      clockgen_powerdown_n,
    output logic                      clockgen_init,
    output logic                      soc_warm_reset_n,
    output logic                      soc_power_on_reset_n,
    output logic                      soc_full_reset_n,
    output logic                      soc_nmi_release,
    output logic [BOOT_W-1:0]         soc_boot_out,
    output logic [BOOT_W-1:0]         soc_boot_oe,
    output logic                      soc_outputs_locked,
    output logic                      seq_running
);

    // Reset synchroniser: async assert, clocked release
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Settle target in ms for a given state
    function automatic logic [pwrseq_pkg::MS_W-1:0] settle_ms(input pwrseq_pkg::seq_state_t s);
        case (s)
            pwrseq_pkg::ST_AUX:    settle_ms = 5'(pwrseq_pkg::AUX_SETTLE_MS);
            pwrseq_pkg::ST_RAILS:  settle_ms = 5'(pwrseq_pkg::RAIL_SETTLE_MS);
            pwrseq_pkg::ST_CLKGEN: settle_ms = 5'(pwrseq_pkg::LOCK_SETTLE_MS);
            pwrseq_pkg::ST_LOCK:   settle_ms = 5'(pwrseq_pkg::RST_STEP_MS);
            pwrseq_pkg::ST_POR:    settle_ms = 5'(pwrseq_pkg::RST_STEP_MS);
            pwrseq_pkg::ST_FULL:   settle_ms = 5'(pwrseq_pkg::BOOT_HOLD_MS);
            pwrseq_pkg::ST_PD_RST: settle_ms = 5'(pwrseq_pkg::PD_CLK_MS);
            default:               settle_ms = 5'h01;
        endcase
    endfunction

    // Millisecond tick divider, free running
    logic [pwrseq_pkg::TICK_W-1:0] tick_cnt_r;
    logic [pwrseq_pkg::TICK_W-1:0] tick_cnt_nxt;
    logic                          ms_tick_r;
    logic                          ms_tick_nxt;
    always_comb
    begin
        ms_tick_nxt  = 1'b0;
        tick_cnt_nxt = tick_cnt_r + 16'h0001;
        if (tick_cnt_r == MS_CYCLES - 16'h0001)
        begin
            tick_cnt_nxt = 16'h0000;
            ms_tick_nxt  = 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            tick_cnt_r <= 16'h0000;
            ms_tick_r  <= 1'b0;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_nxt;
            ms_tick_r  <= ms_tick_nxt;
        end
    end

    // Sequencer state
    pwrseq_pkg::seq_state_t         state_r, state_nxt;
    logic [2:0]                     rail_idx_r, rail_idx_nxt;
    logic [pwrseq_pkg::MS_W-1:0]    ms_cnt_r, ms_cnt_nxt;
    logic [NRAIL-1:0]               rail_en_r, rail_en_nxt;
    logic                           aux_en_r, aux_en_nxt;
    logic                           locked_r, locked_nxt;
    logic                           pd_n_r, pd_n_nxt;
    logic                           init_r, init_nxt;
    logic                           running_r, running_nxt;
    pwrseq_pkg::soc_ctl_t           soc_r, soc_nxt;
    logic                           stable_src;
    logic                           settled;

    // Which power-good the current wait watches
    always_comb
    begin
        case (state_r)
            pwrseq_pkg::ST_AUX:    stable_src = aux_power_good;
            pwrseq_pkg::ST_RAILS:  stable_src = rail_power_good[rail_idx_r];
            pwrseq_pkg::ST_CLKGEN: stable_src = soc_power_good && clockgen_locked && rail_power_good[NRAIL-1];
            default:               stable_src = 1'b1;
        endcase
    end
    assign settled = ms_tick_r && (ms_cnt_r + 5'h01 >= settle_ms(state_r));

    // Next-state logic; power failure overrides every step from aux to run
    always_comb
    begin
        state_nxt    = state_r;
        rail_idx_nxt = rail_idx_r;
        ms_cnt_nxt   = ms_cnt_r;
        rail_en_nxt  = rail_en_r;
        aux_en_nxt   = aux_en_r;
        locked_nxt   = locked_r;
        pd_n_nxt     = pd_n_r;
        init_nxt     = 1'b0;
        soc_nxt      = soc_r;
        soc_nxt.boot_out = boot_config;
        if (!stable_src)
            ms_cnt_nxt = 5'h00;
        else if (ms_tick_r)
            ms_cnt_nxt = settled ? 5'h00 : ms_cnt_r + 5'h01;
        case (state_r)
            pwrseq_pkg::ST_OFF:
            begin
                if (payload_present && !power_fail)
                begin
                    aux_en_nxt = 1'b1;
                    locked_nxt = 1'b1;
                    soc_nxt    = '0;
                    pd_n_nxt   = 1'b0;
                    ms_cnt_nxt = 5'h00;
                    state_nxt  = pwrseq_pkg::ST_AUX;
                end
            end
            pwrseq_pkg::ST_AUX:
            begin
                if (settled && stable_src)
                begin
                    rail_en_nxt[pwrseq_pkg::R_CORE_ADAPT] = 1'b1;
                    rail_idx_nxt = 3'h0;
                    state_nxt    = pwrseq_pkg::ST_RAILS;
                end
            end
            pwrseq_pkg::ST_RAILS:
            begin
                // One rail at a time, each waits on its predecessor's good
                if (settled && stable_src)
                begin
                    if (rail_idx_r == pwrseq_pkg::RAIL_LAST)
                    begin
                        pd_n_nxt  = 1'b1;
                        init_nxt  = 1'b1;
                        state_nxt = pwrseq_pkg::ST_CLKGEN;
                    end
                    else
                    begin
                        rail_en_nxt[rail_idx_r + 3'h1] = 1'b1;
                        rail_idx_nxt = rail_idx_r + 3'h1;
                    end
                end
            end
            pwrseq_pkg::ST_CLKGEN:
            begin
                if (settled && stable_src)
                begin
                    soc_nxt.warm_reset_n = 1'b1;
                    soc_nxt.nmi_release  = 1'b1;
                    soc_nxt.boot_oe      = 1'b1;
                    locked_nxt           = 1'b0;
                    state_nxt            = pwrseq_pkg::ST_LOCK;
                end
            end
            pwrseq_pkg::ST_LOCK:
            begin
                if (settled)
                begin
                    soc_nxt.power_on_reset_n = 1'b1;
                    state_nxt = pwrseq_pkg::ST_POR;
                end
            end
            pwrseq_pkg::ST_POR:
            begin
                if (settled)
                begin
                    soc_nxt.full_reset_n = 1'b1;
                    state_nxt = pwrseq_pkg::ST_FULL;
                end
            end
            pwrseq_pkg::ST_FULL:
            begin
                if (settled)
                begin
                    // Boot pins let go here; one step on to run keeps the path Gray
                    soc_nxt.boot_oe = 1'b0;
                    state_nxt = pwrseq_pkg::ST_BOOT;
                end
            end
            pwrseq_pkg::ST_RUN, pwrseq_pkg::ST_BOOT:
                state_nxt = pwrseq_pkg::ST_RUN;
            pwrseq_pkg::ST_PD_RST:
            begin
                if (settled)
                begin
                    locked_nxt = 1'b1;
                    pd_n_nxt   = 1'b0;
                    state_nxt  = pwrseq_pkg::ST_PD_OFF;
                end
            end
            pwrseq_pkg::ST_PD_OFF:
            begin
                rail_en_nxt = '0;
                aux_en_nxt  = 1'b0;
                soc_nxt     = '0;
                state_nxt   = pwrseq_pkg::ST_OFF;
            end
            default:
                state_nxt = pwrseq_pkg::ST_OFF;
        endcase
        // Failure while powered: resets drop on the next clock edge
        if ((power_fail || !payload_present) && state_r != pwrseq_pkg::ST_OFF
            && state_r != pwrseq_pkg::ST_PD_RST && state_r != pwrseq_pkg::ST_PD_OFF)
        begin
            soc_nxt.full_reset_n     = 1'b0;
            soc_nxt.power_on_reset_n = 1'b0;
            soc_nxt.warm_reset_n     = 1'b0;
            soc_nxt.boot_oe          = 1'b0;
            init_nxt                 = 1'b0;
            ms_cnt_nxt               = 5'h00;
            state_nxt                = pwrseq_pkg::ST_PD_RST;
        end
        // Run flag registered so the status pin comes from a flop
        running_nxt = (state_nxt == pwrseq_pkg::ST_RUN);
    end

    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            state_r    <= pwrseq_pkg::ST_OFF;
            rail_idx_r <= 3'h0;
            ms_cnt_r   <= 5'h00;
            rail_en_r  <= '0;
            aux_en_r   <= 1'b0;
            locked_r   <= 1'b1;
            pd_n_r     <= 1'b0;
            init_r     <= 1'b0;
            running_r  <= 1'b0;
            soc_r      <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            rail_idx_r <= rail_idx_nxt;
            ms_cnt_r   <= ms_cnt_nxt;
            rail_en_r  <= rail_en_nxt;
            aux_en_r   <= aux_en_nxt;
            locked_r   <= locked_nxt;
            pd_n_r     <= pd_n_nxt;
            init_r     <= init_nxt;
            running_r  <= running_nxt;
            soc_r      <= soc_nxt;
        end
    end

    // Outputs, all straight from flip-flops; locked is a status output and gates no SoC pin
    assign auxiliary_rail_3v3   = aux_en_r;
    assign logic_core_rail_1v2  = aux_en_r;
    assign logic_io_rail_1v8    = aux_en_r;
    assign rail_enable          = rail_en_r;
    assign clockgen_powerdown_n = pd_n_r;
    assign clockgen_init        = init_r;
    assign soc_warm_reset_n     = soc_r.warm_reset_n;
    assign soc_power_on_reset_n = soc_r.power_on_reset_n;
    assign soc_full_reset_n     = soc_r.full_reset_n;
    assign soc_nmi_release      = soc_r.nmi_release;
    assign soc_boot_out         = soc_r.boot_out;
    assign soc_boot_oe          = {BOOT_W{soc_r.boot_oe}};
    assign soc_outputs_locked   = locked_r;
    assign seq_running          = running_r;

endmodule

/* verification/pwr_partner.sv */
`timescale 1ns/1ps
module pwr_partner (
    input  wire logic       mclk,
    input  wire logic [9:0] en,
    input  wire logic [2:0] dly,
    input  wire logic       glitch,
    output logic [9:0]      good
);
    logic [9:0] hist_r [0:7];

    // Good follows enable after dly cycles and drops with it at once
    always_ff @(posedge mclk)
    begin
        hist_r[0] <= en;
        for (int i = 1; i < 8; i++)
            hist_r[i] <= hist_r[i-1];
    end
    // Commanded aux dip stands in for a brownout in mid-settle
    assign good = hist_r[dly - 3'h1] & en & {9'h1FF, ~glitch};
endmodule

/* verification/pwrseq_asserts.sv */
`timescale 1ns/1ps
module pwrseq_asserts #(
    parameter int          NRAIL     = 8,
    parameter int          BOOT_W    = 8,
    parameter logic [15:0] MS_CYCLES = 16'h0010
) (
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic              payload_present,
    input wire logic              power_fail,
    input wire logic              aux_power_good,
    input wire logic [NRAIL-1:0]  rail_power_good,
    input wire logic              soc_power_good,
    input wire logic              clockgen_locked,
    input wire logic [BOOT_W-1:0] boot_config,
    input wire logic              auxiliary_rail_3v3,
    input wire logic              logic_core_rail_1v2,
    input wire logic              logic_io_rail_1v8,
    input wire logic [NRAIL-1:0]  rail_enable,
    input wire logic              clockgen_powerdown_n,
    input wire logic              clockgen_init,
    input wire logic              soc_warm_reset_n,
    input wire logic              soc_power_on_reset_n,
    input wire logic              soc_full_reset_n,
    input wire logic              soc_nmi_release,
    input wire logic [BOOT_W-1:0] soc_boot_out,
    input wire logic [BOOT_W-1:0] soc_boot_oe,
    input wire logic              soc_outputs_locked
);
    localparam int MS = int'(MS_CYCLES);
    logic       pre;
    logic [3:0] rst_now;
    logic [3:0] rst_r;
    int         run_r;
    int         run_nxt;
    int         step_r;
    int         step_nxt;
    int         lock_r;
    int         lock_nxt;

    // Newest enabled rail is what the next step waits on
    always_comb
    begin
        pre = aux_power_good;
        for (int i = 0; i < NRAIL; i++)
            if (rail_enable[i])
                pre = rail_power_good[i];
        rst_now  = {soc_warm_reset_n, soc_power_on_reset_n, soc_full_reset_n, |soc_boot_oe};
        run_nxt  = pre ? run_r + 1 : 0;
        step_nxt = (rst_now == rst_r) ? step_r + 1 : 0;
        // Time that SoC good and clock lock have both held
        lock_nxt = (soc_power_good && clockgen_locked) ? lock_r + 1 : 0;
    end

    // Cleared with the design so no time carries over a reset
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            run_r  <= 0;
            step_r <= 0;
            lock_r <= 0;
            rst_r  <= 4'h0;
        end
        else
        begin
            run_r  <= run_nxt;
            step_r <= step_nxt;
            lock_r <= lock_nxt;
            rst_r  <= rst_now;
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!nrst);

    aux_first_a: assert property (rail_enable != '0 |-> auxiliary_rail_3v3 && logic_core_rail_1v2)
        else $error("rail before aux");
    locked_quiet_a: assert property (soc_outputs_locked |-> !soc_warm_reset_n && soc_boot_oe == '0)
        else $error("locked outputs active");
    rail_order_a: assert property ($changed(rail_enable) |->
        rail_enable == '0 || rail_enable == {$past(rail_enable[NRAIL-2:0]), 1'b1})
        else $error("rail order");
    rail_settle_a: assert property ($changed(rail_enable) && rail_enable != '0 |->
        run_r >= (rail_enable == 1 ? 14 : 4) * MS)
        else $error("rail settle short");
    clk_release_a: assert property ($rose(clockgen_powerdown_n) |-> clockgen_init && &rail_enable && run_r >= 4 * MS)
        else $error("clock release early");
    warm_release_a: assert property ($rose(soc_warm_reset_n) |-> soc_nmi_release && clockgen_locked &&
        lock_r >= 4 * MS)
        else $error("warm release early");
    boot_drive_a: assert property (soc_boot_oe != '0 |-> soc_boot_oe == '1 && soc_boot_out == $past(boot_config))
        else $error("boot drive");
    por_step_a: assert property ($rose(soc_power_on_reset_n) |-> step_r >= 4 * MS && step_r <= 5 * MS + 3)
        else $error("por step");
    full_step_a: assert property ($rose(soc_full_reset_n) |-> step_r >= 4 * MS && step_r <= 5 * MS + 3)
        else $error("full step");
    boot_release_a: assert property ($fell(|soc_boot_oe) && soc_full_reset_n |-> step_r <= MS + 3)
        else $error("boot release late");
    fail_reset_a: assert property ((power_fail || !payload_present) && auxiliary_rail_3v3 |=>
        !soc_full_reset_n && !soc_power_on_reset_n)
        else $error("fail reset late");
    pd_clock_a: assert property ($fell(clockgen_powerdown_n) |-> soc_outputs_locked ##1
        !auxiliary_rail_3v3 && !logic_io_rail_1v8 && rail_enable == '0)
        else $error("power-down order");
    reset_order_a: assert property ((!soc_full_reset_n || soc_power_on_reset_n) &&
        (!soc_power_on_reset_n || soc_warm_reset_n) && (!soc_warm_reset_n || clockgen_powerdown_n))
        else $error("reset order");
endmodule

bind board_power_reset_sequencer pwrseq_asserts #(.NRAIL(NRAIL), .BOOT_W(BOOT_W), .MS_CYCLES(MS_CYCLES)) chk (.*);

/* verification/board_power_reset_sequencer_tb.sv */
`timescale 1ns/1ps
module board_power_reset_sequencer_tb;
    localparam int MS = 16;
    logic       mclk = 1'b0, nrst = 1'b0, payload_present = 1'b0, power_fail = 1'b0, glitch = 1'b0;
    logic [2:0] dly = 3'h1;
    logic [7:0] boot_config = 8'h00, bc_prev, rail_power_good, rail_enable, soc_boot_out, soc_boot_oe;
    logic [9:0] good;
    logic       aux_power_good, soc_power_good, clockgen_locked, auxiliary_rail_3v3, logic_core_rail_1v2;
    logic       logic_io_rail_1v8, clockgen_powerdown_n, clockgen_init, soc_warm_reset_n, soc_power_on_reset_n;
    logic       soc_full_reset_n, soc_nmi_release, soc_outputs_locked, seq_running;
    int         cyc = 0, n_errors = 0, checks_done = 0;
    int         step_ms[$] = '{0, 15, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 1};

    board_power_reset_sequencer #(.MS_CYCLES(16'h0010)) dut (.*);
    pwr_partner far (.mclk(mclk), .en({clockgen_powerdown_n, rail_enable, auxiliary_rail_3v3}), .dly(dly),
                     .glitch(glitch), .good(good));
    assign aux_power_good  = good[0];
    assign rail_power_good = good[8:1];
    assign soc_power_good  = good[8];
    assign clockgen_locked = good[9];

    always #10 mclk = ~mclk;

    // Fresh boot value every cycle so a stale capture shows
    always @(posedge mclk)
    begin
        cyc         <= cyc + 1;
        boot_config <= 8'($urandom);
        bc_prev     <= boot_config;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic obs(input int k);
        case (k)
            0:       return auxiliary_rail_3v3;
            9:       return clockgen_powerdown_n;
            10:      return soc_warm_reset_n;
            11:      return soc_power_on_reset_n;
            12:      return soc_full_reset_n;
            13:      return soc_boot_oe == 8'h00;
            14:      return !auxiliary_rail_3v3;
            default: return rail_enable[k-1];
        endcase
    endfunction

    // Bounded wait; a miss shows up as a failed check
    task automatic wait_obs(input int k, output int te);
        int n;
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (obs(k) !== 1'b1 && n < 20 * MS + 50);
        check(obs(k), 1'b1);
        te = cyc;
    endtask

    // Each step timed from when its prerequisite went good
    task automatic power_up(input bit dip, input int last);
        int t_prev, te, lo;
        // Inputs only move on a rising edge
        @(posedge mclk);
        payload_present <= 1'b1;
        dly             <= 3'(1 + $urandom % 4);
        t_prev = cyc;
        for (int s = 0; s <= last; s++)
        begin
            if (s == 1 && dip)
            begin
                repeat (10 * MS) @(posedge mclk);
                glitch <= 1'b1;
                repeat (3) @(posedge mclk);
                glitch <= 1'b0;
                t_prev = cyc - dly;
            end
            wait_obs(s, te);
            lo = step_ms[s] > 0 ? (step_ms[s] - 1) * MS : 0;
            te = te - t_prev - ((s >= 1 && s <= 10) ? dly : 0);
            check(32'(te >= lo && te <= step_ms[s] * MS + 4), 32'h1);
            t_prev = cyc;
            if (s == 0)
                check({soc_outputs_locked, soc_full_reset_n, clockgen_powerdown_n, logic_io_rail_1v8}, 4'h9);
            if (s == 9)
                check(clockgen_init, 1'b1);
            if (s == 10)
                check({soc_nmi_release, soc_outputs_locked, soc_boot_oe, soc_boot_out}, {2'b10, 8'hFF, bc_prev});
        end
        if (last == 13)
        begin
            @(negedge mclk);
            check(seq_running, 1'b1);
        end
    endtask

    // Failure from run or mid-ramp: resets at once, clocks after the wait, rails last
    task automatic power_down(input bit unplug);
        int t0, te;
        @(posedge mclk);
        if (unplug)
            payload_present <= 1'b0;
        else
            power_fail <= 1'b1;
        t0 = cyc;
        repeat (2) @(negedge mclk);
        check({soc_full_reset_n, soc_power_on_reset_n, soc_boot_oe}, 32'h0);
        wait_obs(14, te);
        check(32'(te - t0 >= 4 * MS && te - t0 <= 5 * MS + 4), 32'h1);
        check({rail_enable, logic_core_rail_1v2, clockgen_powerdown_n, soc_outputs_locked}, 32'h1);
    endtask

    initial
    begin
        void'($urandom(77382));
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        power_up(1'b1, 13);
        power_down(1'b0);
        // Fail still high: a present payload must not restart the ramp
        repeat (2 * MS) @(posedge mclk);
        check(auxiliary_rail_3v3, 1'b0);
        power_fail <= 1'b0;
        power_up(1'b0, 4);
        power_down(1'b1);
        power_up(1'b0, 1);
        // Async reset in mid-ramp drops everything before the next edge
        @(posedge mclk);
        nrst <= 1'b0;
        #1;
        check({auxiliary_rail_3v3, rail_enable, soc_full_reset_n, clockgen_powerdown_n}, 32'h0);
        summarize();
    end

    // Whole run is a few thousand cycles; this allows ten times that
    initial
    begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        summarize();
    end
endmodule
